/* File: design/cwl_pkg.sv */
// Package for the configuration word loader and decoder.
// Assumes a flash read port that answers one word per request.
`default_nettype none
package cwl_pkg;
  // ==========================================================
  // Addresses and widths
  localparam int unsigned WORD_W = 24;
  localparam int unsigned ADDR_W = 16;
  localparam logic [15:0] ADDR_WORD_TWO = 16'h57fc;
  localparam logic [15:0] ADDR_WORD_ONE = 16'h57fe;
  localparam logic [7:0] UPPER_ONES = 8'hff;
  // ==========================================================
  // Field positions, word two
  localparam int unsigned W2_TWO_SPEED = 15;
  localparam int unsigned W2_PWM_LOCK = 14;
  localparam int unsigned W2_PWM_PIN = 13;
  localparam int unsigned W2_WIN_LO = 11;
  localparam int unsigned W2_OSC_LO = 8;
  localparam int unsigned W2_CKSM_LO = 6;
  localparam int unsigned W2_SECOND_OSCILLATOR_PIN_FN = 5;
  localparam int unsigned W2_ONE_WAY = 4;
  localparam int unsigned W2_PWM_LOW_SIDE_POLARITY = 3;
  localparam int unsigned W2_POSC_LO = 0;
  // ==========================================================
  // Field positions, word one
  localparam int unsigned W1_CODE_PROT = 13;
  localparam int unsigned W1_WRITE_PROT = 12;
  localparam int unsigned W1_PWM_HIGH_SIDE_POLARITY = 10;
  localparam int unsigned W1_WDT_FORCE = 7;
  localparam int unsigned W1_WIN_DIS = 6;
  // ==========================================================
  // Reset value of shadow word two: everything unprogrammed except the factory SECOND_OSCILLATOR_PIN bit.
  localparam logic [23:0] SHADOW_RESET = 24'hffffdf;
  localparam logic [23:0] PWM_MASK_TWO = 24'h006008;
  localparam logic [23:0] PWM_MASK_ONE = 24'h000400;
  // ==========================================================
  // Encodings
  typedef enum logic [2:0] {
    CWL_OSC_FRC = 3'b000, CWL_OSC_FRCDIV_PLL = 3'b001, CWL_OSC_PRI = 3'b010,
    CWL_OSC_PRI_PLL = 3'b011, CWL_OSC_SEC = 3'b100, CWL_OSC_LOW_POWER_INTERNAL_RC = 3'b101,
    CWL_OSC_RSVD = 3'b110, CWL_OSC_FRCDIV = 3'b111
  } cwl_osc_e;
  typedef enum logic [1:0] {
    CWL_POSC_EC = 2'b00, CWL_POSC_MS = 2'b01, CWL_POSC_HS = 2'b10, CWL_POSC_OFF = 2'b11
  } cwl_posc_e;
  typedef enum logic [1:0] {
    CWL_ST_RD_TWO = 2'b00, CWL_ST_RD_ONE = 2'b01, CWL_ST_DONE = 2'b10
  } cwl_state_e;
  // Window size in thousandths: 240, 375, 500, 750 per mille.
  localparam logic [9:0] WIN_PM_11 = 10'h0f0;
  localparam logic [9:0] WIN_PM_10 = 10'h177;
  localparam logic [9:0] WIN_PM_01 = 10'h1f4;
  localparam logic [9:0] WIN_PM_00 = 10'h2ee;
  // ==========================================================
  // Decoded settings
  typedef struct packed {
    logic code_protect;
    logic write_protect;
    logic two_speed_startup;
    logic pwm_key_lock;
    logic pwm_reset_pin_mode;
    logic pwm_high_polarity;
    logic pwm_low_polarity;
    logic [9:0] wdt_window_permille;
    logic [2:0] osc_source;
    logic osc_source_reserved;
    logic clock_switch_enable;
    logic fail_safe_monitor_enable;
    logic pin_select_one_way;
    logic second_oscillator_pin_clock_out;
    logic second_oscillator_pin_gpio;
    logic [1:0] primary_osc_mode;
    logic primary_osc_enable;
    logic wdt_forced_on;
    logic wdt_window_mode;
  } cwl_cfg_s;
endpackage
`default_nettype wire

/* File: design/cwl_decode.sv */
// Pure field decoder from the two shadow words to the settings struct.
// Assumes the shadows already hold their read-back form.
`default_nettype none
module cwl_decode (
  // Shadow words
  input wire logic [23:0] i_word_two,
  input wire logic [23:0] i_word_one,
  // Settings
  output cwl_pkg::cwl_cfg_s o_cfg
);
  // ==========================================================
  // Field extraction
  wire logic [1:0] win_f = i_word_two[cwl_pkg::W2_WIN_LO +: 2];
  wire logic [1:0] cksm_f = i_word_two[cwl_pkg::W2_CKSM_LO +: 2];
  wire logic [1:0] posc_f = i_word_two[cwl_pkg::W2_POSC_LO +: 2];
  wire logic crystal = (posc_f == cwl_pkg::CWL_POSC_MS) || (posc_f == cwl_pkg::CWL_POSC_HS);
  wire logic [9:0] win_pm = (win_f == 2'h3) ? cwl_pkg::WIN_PM_11 :
                            (win_f == 2'h2) ? cwl_pkg::WIN_PM_10 :
                            (win_f == 2'h1) ? cwl_pkg::WIN_PM_01 : cwl_pkg::WIN_PM_00;
  assign o_cfg.code_protect = !i_word_one[cwl_pkg::W1_CODE_PROT];
  assign o_cfg.write_protect = !i_word_one[cwl_pkg::W1_WRITE_PROT];
  assign o_cfg.two_speed_startup = i_word_two[cwl_pkg::W2_TWO_SPEED];
  assign o_cfg.pwm_key_lock = i_word_two[cwl_pkg::W2_PWM_LOCK];
  assign o_cfg.pwm_reset_pin_mode = i_word_two[cwl_pkg::W2_PWM_PIN];
  assign o_cfg.pwm_high_polarity = i_word_one[cwl_pkg::W1_PWM_HIGH_SIDE_POLARITY];
  assign o_cfg.pwm_low_polarity = i_word_two[cwl_pkg::W2_PWM_LOW_SIDE_POLARITY];
  assign o_cfg.wdt_window_permille = win_pm;
  assign o_cfg.osc_source = i_word_two[cwl_pkg::W2_OSC_LO +: 3];
  assign o_cfg.osc_source_reserved = i_word_two[cwl_pkg::W2_OSC_LO +: 3] == cwl_pkg::CWL_OSC_RSVD;
  assign o_cfg.clock_switch_enable = !cksm_f[1];
  assign o_cfg.fail_safe_monitor_enable = cksm_f == 2'h0;
  assign o_cfg.pin_select_one_way = i_word_two[cwl_pkg::W2_ONE_WAY];
  assign o_cfg.second_oscillator_pin_clock_out = !crystal && i_word_two[cwl_pkg::W2_SECOND_OSCILLATOR_PIN_FN];
  assign o_cfg.second_oscillator_pin_gpio = !crystal && !i_word_two[cwl_pkg::W2_SECOND_OSCILLATOR_PIN_FN];
  assign o_cfg.primary_osc_mode = posc_f;
  assign o_cfg.primary_osc_enable = posc_f != cwl_pkg::CWL_POSC_OFF;
  assign o_cfg.wdt_forced_on = i_word_one[cwl_pkg::W1_WDT_FORCE];
  assign o_cfg.wdt_window_mode = !i_word_one[cwl_pkg::W1_WIN_DIS];
endmodule
`default_nettype wire

/* File: design/cwl_loader.sv */
// Configuration word loader: fetches both words after every reset and
// holds decoded settings for the clock, watchdog, protection, pin-select and PWM logic.
// Assumes a flash read port with a one-cycle-or-longer valid answer.
`default_nettype none
module cwl_loader #(
  parameter bit HAS_PWM = 1'b1
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Flash read port
  output logic o_flash_rd,
  output logic [15:0] o_flash_addr,
  input wire logic i_flash_valid,
  input wire logic [23:0] i_flash_data,
  // Shadow read-back
  output logic [23:0] o_word_two,
  output logic [23:0] o_word_one,
  // Status and settings
  output logic o_cfg_valid,
  output cwl_pkg::cwl_cfg_s o_cfg
);
  // ==========================================================
  // Load sequencer
  cwl_pkg::cwl_state_e state;
  cwl_pkg::cwl_state_e next_state;
  logic [23:0] shadow_two;
  logic [23:0] shadow_one;
  logic rd_pend;
  cwl_pkg::cwl_cfg_s dec_cfg;
  wire logic take_two = (state == cwl_pkg::CWL_ST_RD_TWO) && i_flash_valid && rd_pend;
  wire logic take_one = (state == cwl_pkg::CWL_ST_RD_ONE) && i_flash_valid && rd_pend;
  // Upper byte forced high: those cells are not implemented.
  wire logic [23:0] fixed_data = {cwl_pkg::UPPER_ONES, i_flash_data[15:0]};
  wire logic [23:0] pwm_two = HAS_PWM ? 24'h000000 : cwl_pkg::PWM_MASK_TWO;
  wire logic [23:0] pwm_one = HAS_PWM ? 24'h000000 : cwl_pkg::PWM_MASK_ONE;
  wire logic [23:0] next_two = fixed_data | pwm_two;
  wire logic [23:0] next_one = fixed_data | pwm_one;

  always_comb begin
    next_state = state;
    unique case (state)
      cwl_pkg::CWL_ST_RD_TWO: if (take_two) next_state = cwl_pkg::CWL_ST_RD_ONE;
      cwl_pkg::CWL_ST_RD_ONE: if (take_one) next_state = cwl_pkg::CWL_ST_DONE;
      cwl_pkg::CWL_ST_DONE: next_state = cwl_pkg::CWL_ST_DONE;
      default: next_state = cwl_pkg::CWL_ST_RD_TWO;
    endcase
  end

  // Every reset, power-on or not, restarts the fetch of both words.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state <= cwl_pkg::CWL_ST_RD_TWO;
      rd_pend <= 1'b0;
    end else begin
      state <= next_state;
      rd_pend <= (next_state != cwl_pkg::CWL_ST_DONE) && !(take_two || take_one);
    end
  end

  // Shadow word two starts from the unprogrammed pattern with the factory SECOND_OSCILLATOR_PIN bit clear; word one starts all ones.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      shadow_two <= cwl_pkg::SHADOW_RESET;
      shadow_one <= 24'hffffff;
    end else begin
      if (take_two) shadow_two <= next_two;
      if (take_one) shadow_one <= next_one;
    end
  end

  // ==========================================================
  // Flash requests
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_flash_rd <= 1'b0;
      o_flash_addr <= cwl_pkg::ADDR_WORD_TWO;
    end else begin
      o_flash_rd <= (next_state != cwl_pkg::CWL_ST_DONE) && !(take_two || take_one) && !rd_pend;
      o_flash_addr <= (next_state == cwl_pkg::CWL_ST_RD_ONE) ? cwl_pkg::ADDR_WORD_ONE : cwl_pkg::ADDR_WORD_TWO;
    end
  end

  // ==========================================================
  // Decoding and registered outputs
  cwl_decode u_decode (
    .i_word_two(shadow_two),
    .i_word_one(shadow_one),
    .o_cfg(dec_cfg)
  );

  // Outputs move only once, on the first DONE cycle after loading; after completion the shadows are frozen.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_cfg_valid <= 1'b0;
      o_cfg <= '0;
      o_word_two <= 24'hffffff;
      o_word_one <= 24'hffffff;
    end else begin
      o_cfg_valid <= state == cwl_pkg::CWL_ST_DONE;
      if (state == cwl_pkg::CWL_ST_DONE && !o_cfg_valid) begin
        o_cfg <= dec_cfg;
        o_word_two <= shadow_two;
        o_word_one <= shadow_one;
      end
    end
  end

  // ==========================================================
  // Checks
  stable_out_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_cfg_valid && $past(o_cfg_valid) |-> $stable(o_cfg)) else $error("settings moved after load");
  upper_ones_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_cfg_valid |-> o_word_two[23:16] == 8'hff && o_word_one[23:16] == 8'hff)
    else $error("upper byte not ones");
  load_order_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    take_one |=> state == cwl_pkg::CWL_ST_DONE ##1 o_cfg_valid) else $error("load did not finish");
  code_prot_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_cfg_valid |-> o_cfg.code_protect == !o_word_one[cwl_pkg::W1_CODE_PROT]) else $error("code protect wrong");
  write_prot_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_cfg_valid |-> o_cfg.write_protect == !o_word_one[cwl_pkg::W1_WRITE_PROT]) else $error("write protect wrong");
  clk_switch_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_cfg_valid && o_word_two[7] |-> !o_cfg.clock_switch_enable && !o_cfg.fail_safe_monitor_enable)
    else $error("switching not disabled");
  second_oscillator_pin_fn_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_cfg_valid && o_word_two[1:0] == 2'h0 |-> o_cfg.second_oscillator_pin_clock_out == o_word_two[5])
    else $error("SECOND_OSCILLATOR_PIN function wrong");
  window_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_cfg_valid && o_word_two[12:11] == 2'h3 |-> o_cfg.wdt_window_permille == 10'h0f0)
    else $error("window fraction wrong");
  wdt_mode_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_cfg_valid |-> o_cfg.wdt_window_mode != o_word_one[6] && o_cfg.wdt_forced_on == o_word_one[7])
    else $error("watchdog mode wrong");
  pwm_absent_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_cfg_valid && !HAS_PWM |-> o_cfg.pwm_key_lock && o_cfg.pwm_reset_pin_mode)
    else $error("PWM bits not one");
  load_done_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n) $rose(o_cfg_valid));
  code_prot_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_cfg_valid && o_cfg.code_protect);
  fscm_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_cfg_valid && o_cfg.fail_safe_monitor_enable);
endmodule
`default_nettype wire

/* File: sim/cwl_flash_model.sv */
// Behavioural program flash that answers each read request with one word.
// Assumes the loader keeps at most one request outstanding.
`default_nettype none
module cwl_flash_model (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Read port
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  output logic o_valid,
  output logic [23:0] o_data,
  // Contents and pacing
  input wire logic [23:0] i_word_two,
  input wire logic [23:0] i_word_one,
  input wire logic [3:0] i_delay
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [15:0] addr_q = 16'h0000;
  initial o_valid = 1'b0;
  initial o_data = 24'h000000;
  // Idle data toggles every cycle, so a stale word never looks like a fresh answer.
  always @(posedge i_mclk) begin
    o_valid <= 1'b0;
    o_data <= ~o_data;
    if (!i_rst_n) begin
      pend <= 1'b0;
    end else if (i_rd) begin
      pend <= 1'b1;
      cnt <= i_delay;
      addr_q <= i_addr;
    end else if (pend && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (pend) begin
      pend <= 1'b0;
      o_valid <= 1'b1;
      o_data <= (addr_q == cwl_pkg::ADDR_WORD_TWO) ? i_word_two : i_word_one;
    end
  end
endmodule
`default_nettype wire

/* File: sim/tb_config_word_loader_decoder.sv */
// Self-checking bench for the configuration word loader.
// Assumes the design package and loader are compiled first.
`default_nettype none
module tb_config_word_loader_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, spur = 1'b0, rd, mvalid, b_rd, b_cv, o_cfg_valid;
  logic [3:0] dly = 4'h0;
  logic [15:0] addr, b_addr;
  logic [23:0] mem_two = 24'h0, mem_one = 24'h0, mdata, o_word_two, o_word_one, np_two, np_one;
  logic [47:0] rows [8];
  logic [15:0] rd_log [$];
  cwl_pkg::cwl_cfg_s o_cfg, np_cfg;
  int n_mismatch = 0, samples_checked = 0;
  always #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (rd === 1'b1) rd_log.push_back(addr);
  cwl_flash_model mdl_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_rd(rd), .i_addr(addr), .o_valid(mvalid),
    .o_data(mdata), .i_word_two(mem_two), .i_word_one(mem_one), .i_delay(dly));
  cwl_loader dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .o_flash_rd(rd), .o_flash_addr(addr),
    .i_flash_valid(mvalid | spur), .i_flash_data(mdata), .o_word_two(o_word_two), .o_word_one(o_word_one),
    .o_cfg_valid(o_cfg_valid), .o_cfg(o_cfg));
  // The variant without PWM runs in lockstep, so it shares the flash answers.
  cwl_loader #(.HAS_PWM(1'b0)) nopwm_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .o_flash_rd(b_rd),
    .o_flash_addr(b_addr), .i_flash_valid(mvalid | spur), .i_flash_data(mdata), .o_word_two(np_two),
    .o_word_one(np_one), .o_cfg_valid(b_cv), .o_cfg(np_cfg));
  // ==========================================================
  // Expected settings
  function automatic cwl_pkg::cwl_cfg_s exp_cfg(input logic [23:0] w2, input logic [23:0] w1);
    cwl_pkg::cwl_cfg_s c;
    logic xtal;
    xtal = (w2[1:0] == 2'h1) || (w2[1:0] == 2'h2);
    c.code_protect = ~w1[13];
    c.write_protect = ~w1[12];
    c.two_speed_startup = w2[15];
    c.pwm_key_lock = w2[14];
    c.pwm_reset_pin_mode = w2[13];
    c.pwm_high_polarity = w1[10];
    c.pwm_low_polarity = w2[3];
    case (w2[12:11])
      2'h3: c.wdt_window_permille = 10'h0f0;
      2'h2: c.wdt_window_permille = 10'h177;
      2'h1: c.wdt_window_permille = 10'h1f4;
      default: c.wdt_window_permille = 10'h2ee;
    endcase
    c.osc_source = w2[10:8];
    c.osc_source_reserved = (w2[10:8] == 3'h6);
    c.clock_switch_enable = ~w2[7];
    c.fail_safe_monitor_enable = (w2[7:6] == 2'h0);
    c.pin_select_one_way = w2[4];
    c.second_oscillator_pin_clock_out = w2[5] && !xtal;
    c.second_oscillator_pin_gpio = !w2[5] && !xtal;
    c.primary_osc_mode = w2[1:0];
    c.primary_osc_enable = (w2[1:0] != 2'h3);
    c.wdt_forced_on = w1[7];
    c.wdt_window_mode = ~w1[6];
    return c;
  endfunction
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // One reset and load, optionally cut short by the next reset
  task automatic load(input logic [47:0] r, input logic [3:0] d, input bit abort);
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    {mem_two, mem_one} <= r;
    dly <= d;
    repeat (4) @(posedge i_mclk);
    @(negedge i_mclk);
    check(64'(o_cfg_valid), 64'h0);
    rd_log.delete();
    @(posedge i_mclk);
    i_rst_n <= 1'b1;
    if (abort) repeat (3) @(posedge i_mclk);
    if (abort) return;
    for (int t = 0; t < 100 && o_cfg_valid !== 1'b1; t++) @(negedge i_mclk);
    check(64'(o_cfg_valid), 64'h1);
    check(64'({rd_log.size(), rd_log[0], rd_log[1]}), {32'h2, 32'h57fc57fe});
    check(64'({o_word_two, o_word_one}), 64'({8'hff, r[39:24], 8'hff, r[15:0]}));
    check(64'(o_cfg), 64'(exp_cfg(r[47:24], r[23:0])));
    check(64'(o_cfg), 64'(exp_cfg(r[47:24], r[23:0])));
    check(64'({np_two, np_one}), 64'({8'hff, r[39:24] | 16'h6008, 8'hff, r[15:0] | 16'h0400}));
    check(64'(np_cfg), 64'(exp_cfg(r[47:24] | 24'h006008, r[23:0] | 24'h000400)));
    $display("test load done");
  endtask
  initial begin
    logic [2:0] k;
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      rows[i] = {8'h00, k[0], k[1], k[2], k[1:0], k, k[1:0], ~k[0], k[2], k[0], 1'b1, ~k[1:0],
                 8'h00, 2'b00, k[0], k[1], 1'b1, k[2], 2'b11, k[1], k[2], 6'h3f};
    end
    for (int i = 0; i < 8; i++) load(rows[i], 4'h0, 1'b0);
    load(rows[5], 4'h9, 1'b0);
    load(rows[0], 4'h0, 1'b1);
    load(rows[6], 4'h2, 1'b0);
    @(posedge i_mclk);
    mem_two <= 24'h000000;
    spur <= 1'b1;
    @(posedge i_mclk);
    spur <= 1'b0;
    repeat (10) @(negedge i_mclk);
    check(64'({rd_log.size(), o_word_two}), 64'({32'h2, 8'hff, rows[6][39:24]}));
    check(64'(o_cfg), 64'(exp_cfg(rows[6][47:24], rows[6][23:0])));
    $display("test stable settings done");
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge i_mclk);
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
